/* File: tdr_pkg.sv */
// constants and carrier types for the cable diagnostic register bank
// assumes a single 25 MHz system clock domain shared by all users
package tdr_pkg;

    localparam int ADDR_W = 10;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_DIAG_CONTROL_2 = 10'h171;
    localparam logic [ADDR_W-1:0] OFS_SEGMENT_TIMING = 10'h173;
    localparam logic [ADDR_W-1:0] OFS_SHADOW = 10'h175;
    localparam logic [ADDR_W-1:0] OFS_PEAK_LOC_THRESH = 10'h176;
    localparam logic [ADDR_W-1:0] OFS_SHORT_THRESH = 10'h177;
    localparam logic [ADDR_W-1:0] OFS_PULSE_WIDTH = 10'h178;
    localparam logic [ADDR_W-1:0] OFS_FIRST_PEAK = 10'h180;
    localparam logic [ADDR_W-1:0] OFS_LOC_RESULT_2 = 10'h181;
    localparam logic [ADDR_W-1:0] OFS_LOC_RESULT_3 = 10'h182;
    localparam logic [ADDR_W-1:0] OFS_LOC_RESULT_4 = 10'h183;
    localparam logic [ADDR_W-1:0] OFS_LOC_RESULT_5 = 10'h184;

    // values after reset
    localparam logic [15:0] RST_DIAG_CONTROL_2 = 16'hC850;
    localparam logic [15:0] RST_SEGMENT_TIMING = 16'h0D04;
    localparam logic [15:0] RST_SHADOW = 16'h1004;
    localparam logic [15:0] RST_PEAK_LOC_THRESH = 16'h0005;
    localparam logic [15:0] RST_SHORT_THRESH = 16'h1E00;
    localparam logic [15:0] RST_PULSE_WIDTH = 16'h0002;
    localparam logic [7:0] RST_FIRST_PEAK = 8'h00;

    // writable bits per register, all others read as zero
    localparam logic [15:0] WMASK_SHADOW = 16'h381F;
    localparam logic [15:0] WMASK_PEAK_LOC_THRESH = 16'h001F;
    localparam logic [15:0] WMASK_PULSE_WIDTH = 16'h0007;

    // field positions
    localparam int SEG_DUR_LSB = 8;
    localparam int INIT_SKIP_LSB = 0;
    localparam int SDW_AVG_LSB = 11;
    localparam int FWD_SHADOW_LSB = 0;
    localparam int PLOC_THR_LSB = 0;
    localparam int SHORT_THR_LSB = 8;
    localparam int PULSE_W_LSB = 0;

    // detection threshold beyond the near zone
    localparam logic [7:0] FAR_THRESH = 8'h08;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tdr_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] mag;
    } tdr_sample_t;

    typedef struct packed {
        logic [2:0] pulse_width;
        logic [2:0] sdw_avg_loc;
    } tdr_fe_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PULSE = 2'b01,
        ST_SKIP = 2'b11,
        ST_EVAL = 2'b10
    } tdr_state_t;

endpackage

/* File: tdr_cable_diag_config_regs.sv */
// register bank and first-peak search engine for the cable diagnostic
// assumes bus master and sample source run on clk_sys; samples need no sync
// What this block does
// - segment duration field bounds evaluated sample count
// - initial skip samples discarded before evaluation
// - shadow average location driven to front end
// - forward shadow hides echoes after each peak
// - short-cable threshold applies in near zone
// - pulse width field sizes transmit pulse
// - first peak location readable, read-only
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns

module tdr_cable_diag_config_regs
    import tdr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tdr_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    input wire logic diag_start,
    input wire tdr_sample_t sample,
    output logic tx_pulse,
    output tdr_fe_cfg_t fe_cfg,
    output logic diag_busy,
    output logic diag_done,
    output logic [3:0] peak_count
);

    logic [15:0] diag_control_2;
    logic [15:0] segment_timing_cfg;
    logic [15:0] shadow_cfg;
    logic [15:0] peak_location_threshold;
    logic [15:0] short_cable_threshold_cfg;
    logic [15:0] pulse_width_cfg;
    logic [7:0] first_peak_location;

    tdr_state_t state;
    logic [7:0] step_left;
    logic [7:0] eval_idx;
    logic [7:0] position;
    logic [3:0] shadow_left;
    logic peak_found;

    logic [7:0] seg_duration;
    logic [7:0] initial_skip;
    logic [3:0] fwd_shadow;
    logic [4:0] ploc_thresh;
    logic [4:0] short_thresh;
    logic [2:0] pulse_width;
    logic [7:0] detect_thresh;
    logic is_peak;
    tdr_state_t next_state;
    logic wr_diag_control_2;
    logic wr_segment_timing;
    logic wr_shadow;
    logic wr_peak_loc_thresh;
    logic wr_short_thresh;
    logic wr_pulse_width;

    assign seg_duration = segment_timing_cfg[SEG_DUR_LSB +: 8];
    assign initial_skip = segment_timing_cfg[INIT_SKIP_LSB +: 8];
    assign fwd_shadow = shadow_cfg[FWD_SHADOW_LSB +: 4];
    assign ploc_thresh = peak_location_threshold[PLOC_THR_LSB +: 5];
    assign short_thresh = short_cable_threshold_cfg[SHORT_THR_LSB +: 5];
    assign pulse_width = pulse_width_cfg[PULSE_W_LSB +: 3];

    // write decode; reserved read-write bits are kept as storage
    assign wr_diag_control_2 = bus_req.wr && (bus_req.addr == OFS_DIAG_CONTROL_2);
    assign wr_segment_timing = bus_req.wr && (bus_req.addr == OFS_SEGMENT_TIMING);
    assign wr_shadow = bus_req.wr && (bus_req.addr == OFS_SHADOW);
    assign wr_peak_loc_thresh = bus_req.wr && (bus_req.addr == OFS_PEAK_LOC_THRESH);
    assign wr_short_thresh = bus_req.wr && (bus_req.addr == OFS_SHORT_THRESH);
    assign wr_pulse_width = bus_req.wr && (bus_req.addr == OFS_PULSE_WIDTH);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            diag_control_2 <= RST_DIAG_CONTROL_2;
        end else if (wr_diag_control_2) begin
            diag_control_2 <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            segment_timing_cfg <= RST_SEGMENT_TIMING;
        end else if (wr_segment_timing) begin
            segment_timing_cfg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shadow_cfg <= RST_SHADOW;
        end else if (wr_shadow) begin
            shadow_cfg <= bus_req.wdata & WMASK_SHADOW;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            peak_location_threshold <= RST_PEAK_LOC_THRESH;
        end else if (wr_peak_loc_thresh) begin
            peak_location_threshold <= bus_req.wdata & WMASK_PEAK_LOC_THRESH;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            short_cable_threshold_cfg <= RST_SHORT_THRESH;
        end else if (wr_short_thresh) begin
            short_cable_threshold_cfg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pulse_width_cfg <= RST_PULSE_WIDTH;
        end else if (wr_pulse_width) begin
            pulse_width_cfg <= bus_req.wdata & WMASK_PULSE_WIDTH;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= 16'h0000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_DIAG_CONTROL_2: begin
                    bus_rdata <= diag_control_2;
                end
                OFS_SEGMENT_TIMING: begin
                    bus_rdata <= segment_timing_cfg;
                end
                OFS_SHADOW: begin
                    bus_rdata <= shadow_cfg;
                end
                OFS_PEAK_LOC_THRESH: begin
                    bus_rdata <= peak_location_threshold;
                end
                OFS_SHORT_THRESH: begin
                    bus_rdata <= short_cable_threshold_cfg;
                end
                OFS_PULSE_WIDTH: begin
                    bus_rdata <= pulse_width_cfg;
                end
                OFS_FIRST_PEAK: begin
                    bus_rdata <= {8'h00, first_peak_location};
                end
                default: begin
                    // result slots 2..5 and unmapped addresses read zero
                    bus_rdata <= 16'h0000;
                end
            endcase
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // front end settings follow the registers live
    assign fe_cfg.sdw_avg_loc = shadow_cfg[SDW_AVG_LSB +: 3];
    assign fe_cfg.pulse_width = pulse_width;

    assign diag_busy = (state != ST_IDLE);
    assign tx_pulse = (state == ST_PULSE);

    // near zone uses the short-cable threshold against strong close echoes
    assign detect_thresh = (eval_idx < {3'h0, ploc_thresh}) ? {3'h0, short_thresh} : FAR_THRESH;
    assign is_peak = sample.valid && (shadow_left == 4'h0) && (sample.mag > detect_thresh);

    // sequence: pulse, skip, evaluate; a start while busy is ignored
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (diag_start) begin
                    next_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (step_left == 8'h00) begin
                    next_state = ST_SKIP;
                end
            end
            ST_SKIP: begin
                if (step_left == 8'h00) begin
                    next_state = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (step_left == 8'h00) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // phase counter: pulse in cycles, skip and duration in valid samples
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            step_left <= 8'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (diag_start) begin
                        step_left <= {5'h00, pulse_width};
                    end
                end
                ST_PULSE: begin
                    if (step_left == 8'h00) begin
                        step_left <= initial_skip;
                    end else begin
                        step_left <= step_left - 8'h01;
                    end
                end
                ST_SKIP: begin
                    if (step_left == 8'h00) begin
                        step_left <= seg_duration;
                    end else if (sample.valid) begin
                        step_left <= step_left - 8'h01;
                    end
                end
                ST_EVAL: begin
                    if (step_left != 8'h00 && sample.valid) begin
                        step_left <= step_left - 8'h01;
                    end
                end
            endcase
        end
    end

    // index of the evaluated sample, only read while evaluating
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            eval_idx <= 8'h00;
        end else if (state == ST_SKIP) begin
            eval_idx <= 8'h00;
        end else if (state == ST_EVAL && step_left != 8'h00 && sample.valid) begin
            eval_idx <= eval_idx + 8'h01;
        end
    end

    // one-cycle done pulse as the evaluation ends
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            diag_done <= 1'b0;
        end else begin
            diag_done <= (state == ST_EVAL) && (step_left == 8'h00);
        end
    end

    // sample position counted from the end of the pulse, saturating
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            position <= 8'h00;
        end else if (state == ST_PULSE) begin
            position <= 8'h00;
        end else if ((state == ST_SKIP || state == ST_EVAL) && sample.valid && position != 8'hFF) begin
            position <= position + 8'h01;
        end
    end

    // peak search; shadow masks echoes of a found peak
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shadow_left <= 4'h0;
            peak_found <= 1'b0;
            peak_count <= 4'h0;
            first_peak_location <= RST_FIRST_PEAK;
        end else if (state == ST_IDLE && diag_start) begin
            shadow_left <= 4'h0;
            peak_found <= 1'b0;
            peak_count <= 4'h0;
            first_peak_location <= RST_FIRST_PEAK;
        end else if (state == ST_EVAL && step_left != 8'h00 && sample.valid) begin
            if (shadow_left != 4'h0) begin
                shadow_left <= shadow_left - 4'h1;
            end else if (is_peak) begin
                shadow_left <= fwd_shadow;
                if (peak_count != 4'hF) begin
                    peak_count <= peak_count + 4'h1;
                end
                if (!peak_found) begin
                    peak_found <= 1'b1;
                    first_peak_location <= position;
                end
            end
        end
    end

endmodule

/* File: tdr_cable_diag_config_regs_checker.sv */
// port assertions for the cable diagnostic register bank
// assumes one clk_sys domain and rstn asynchronous active low
`timescale 1ns/1ns
module tdr_cable_diag_config_regs_checker
    import tdr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tdr_bus_req_t bus_req,
    input wire logic [15:0] bus_rdata,
    input wire logic diag_start,
    input wire tdr_sample_t sample,
    input wire logic tx_pulse,
    input wire tdr_fe_cfg_t fe_cfg,
    input wire logic diag_busy,
    input wire logic diag_done,
    input wire logic [3:0] peak_count
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // length of the current transmit pulse so far
    logic [3:0] tx_len;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_len <= 4'h0;
        end else begin
            tx_len <= tx_pulse ? tx_len + 4'h1 : 4'h0;
        end
    end
    property p_rdata_idle;
        !bus_req.rd |=> bus_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_pw;
        logic [2:0] v;
        (bus_req.wr && bus_req.addr == OFS_PULSE_WIDTH, v = bus_req.wdata[2:0]) |=> fe_cfg.pulse_width == v;
    endproperty
    a_pw: assert property (p_pw) else $error("pulse width not following register");
    property p_sdw;
        logic [2:0] v;
        (bus_req.wr && bus_req.addr == OFS_SHADOW, v = bus_req.wdata[13:11]) |=> fe_cfg.sdw_avg_loc == v;
    endproperty
    a_sdw: assert property (p_sdw) else $error("shadow average location not following register");
    property p_tx_len;
        $fell(tx_pulse) |-> tx_len == {1'b0, fe_cfg.pulse_width} + 4'h1;
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("transmit pulse length wrong");
    property p_start;
        diag_start && !diag_busy |=> diag_busy && tx_pulse && peak_count == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_done;
        diag_done |-> !diag_busy && $past(diag_busy) ##1 !diag_done;
    endproperty
    a_done: assert property (p_done) else $error("done pulse malformed");
    property p_hold;
        !diag_busy && !diag_start |=> $stable(peak_count);
    endproperty
    a_hold: assert property (p_hold) else $error("peak count changed while idle");
    property p_step;
        diag_busy |=> peak_count == $past(peak_count) || peak_count == $past(peak_count) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("peak count jumped");
endmodule

bind tdr_cable_diag_config_regs tdr_cable_diag_config_regs_checker u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .diag_start(diag_start), .sample(sample), .tx_pulse(tx_pulse),
    .fe_cfg(fe_cfg), .diag_busy(diag_busy), .diag_done(diag_done), .peak_count(peak_count));

/* File: tdr_cable_diag_config_regs_tb_top.sv */
// self-checking bench for the cable diagnostic register bank
// assumes bench is bus master and echo source on clk_sys
`timescale 1ns/1ns
module tdr_cable_diag_config_regs_tb_top;
    import tdr_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    tdr_bus_req_t bus_req = '0;
    logic diag_start = 1'b0;
    tdr_sample_t sample = '0;
    logic [15:0] bus_rdata, rd_val;
    logic tx_pulse, diag_busy, diag_done;
    tdr_fe_cfg_t fe_cfg;
    logic [3:0] peak_count;
    int n_errors = 0;
    int checked = 0;
    tdr_sample_t seq [$];
    // offset 0x172 and 0x179 are holes in the map
    logic [9:0] adr [13] = '{10'h171, 10'h173, 10'h175, 10'h176, 10'h177, 10'h178, 10'h180, 10'h181, 10'h182,
        10'h183, 10'h184, 10'h172, 10'h179};
    logic [15:0] rst [13] = '{16'hC850, 16'h0D04, 16'h1004, 16'h0005, 16'h1E00, 16'h0002, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] msk [13] = '{16'hFFFF, 16'hFFFF, 16'h381F, 16'h001F, 16'hFFFF, 16'h0007, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // last entry is a corner: no skip, no shadow, every sample a peak
    logic [7:0] t_dur [6] = '{8'h0D, 8'h0D, 8'h1A, 8'h34, 8'h8F, 8'h14};
    logic [7:0] t_skp [6] = '{8'h07, 8'h14, 8'h21, 8'h3B, 8'h6F, 8'h00};
    logic [3:0] t_fwd [6] = '{4'h4, 4'h4, 4'h5, 4'h8, 4'hB, 4'h0};
    logic [2:0] t_pw [6] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h6, 3'h0};

    tdr_cable_diag_config_regs tdr_cable_diag_config_regs_inst (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .diag_start(diag_start), .sample(sample), .tx_pulse(tx_pulse), .fe_cfg(fe_cfg),
        .diag_busy(diag_busy), .diag_done(diag_done), .peak_count(peak_count));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // detection threshold expected for evaluated sample e
    function automatic logic [7:0] exp_thresh(input int e, input logic [4:0] near, input logic [4:0] thr);
        return (e < int'(near)) ? {3'h0, thr} : FAR_THRESH;
    endfunction

    // a gap cycle after each access keeps one assignment per time step
    task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
        rd_val = bus_rdata;
    endtask

    task automatic final_report;
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_errors++;
        final_report();
    end

    initial begin
        logic [15:0] d;
        logic [7:0] dur, skp, m, exp_loc;
        logic [3:0] fwd, shd, exp_cnt;
        logic [2:0] pw;
        logic [4:0] near, thr;
        void'($urandom(32'hce989c41));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 13; i++) begin
            d = 16'($urandom);
            acc(1'b0, adr[i], 16'h0000);
            cmp(rd_val, rst[i]);
            acc(1'b1, adr[i], d);
            acc(1'b0, adr[i], 16'h0000);
            cmp(rd_val, d & msk[i]);
        end
        exp_loc = 8'h00;
        for (int s = 0; s < 6; s++) begin
            dur = t_dur[s];
            skp = t_skp[s];
            fwd = t_fwd[s];
            pw = t_pw[s];
            near = 5'($urandom);
            thr = 5'($urandom);
            acc(1'b1, 10'h173, {dur, skp});
            acc(1'b1, 10'h175, {2'b00, 3'h2, 7'h00, fwd});
            acc(1'b1, 10'h176, {11'h000, near});
            acc(1'b1, 10'h177, {3'h0, thr, 8'h00});
            acc(1'b1, 10'h178, {13'h0000, pw});
            cmp({10'h000, fe_cfg}, {10'h000, pw, 3'h2});
            // result of the previous run must survive reconfiguration
            acc(1'b0, 10'h180, 16'h0000);
            cmp(rd_val, {8'h00, exp_loc});
            seq = {};
            exp_loc = 8'h00;
            exp_cnt = 4'h0;
            shd = 4'h0;
            // skipped echoes are huge so any peak among them shows
            for (int k = 0; k < skp; k++) seq.push_back('{1'b1, 8'hFF});
            seq.push_back('{1'b0, 8'hFF});
            for (int e = 0; e < dur; e++) begin
                m = (s == 5) ? 8'hFF : 8'($urandom % 48);
                if ($urandom % 4 == 0) seq.push_back('{1'b0, 8'hFF});
                seq.push_back('{1'b1, m});
                if (shd != 4'h0) begin
                    shd--;
                end else if (m > exp_thresh(e, near, thr)) begin
                    if (exp_cnt == 4'h0) exp_loc = skp + 8'(e);
                    if (exp_cnt != 4'hF) exp_cnt++;
                    shd = fwd;
                end
            end
            seq.push_back('{1'b0, 8'h00});
            diag_start <= 1'b1;
            @(posedge clk_sys);
            diag_start <= 1'b0;
            repeat (pw + 2) @(posedge clk_sys);
            // a second start mid-run must be ignored
            foreach (seq[i]) begin
                sample <= seq[i];
                diag_start <= (i == 2);
                @(posedge clk_sys);
            end
            for (int w = 0; w < 8 && diag_done !== 1'b1; w++) @(posedge clk_sys);
            cmp({15'h0000, diag_done}, 16'h0001);
            cmp({12'h000, peak_count}, {12'h000, exp_cnt});
            acc(1'b0, 10'h180, 16'h0000);
            cmp(rd_val, {8'h00, exp_loc});
        end
        final_report();
    end
endmodule
